// *** design/ioexp_pkg.sv ***
/*
  Package for the eight-line open-drain I/O expander with SMBus slave:
  command codes, reset values, address constants and carrier structs.
  Assumes nothing of its surroundings.
*/
package ioexp_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_NORMAL_OUT = 8'h00;
  localparam logic [7:0] CMD_NORMAL_RISE = 8'h01;
  localparam logic [7:0] CMD_NORMAL_FALL = 8'h02;
  localparam logic [7:0] CMD_SUSP_OUT = 8'h03;
  localparam logic [7:0] CMD_SUSP_RISE = 8'h04;
  localparam logic [7:0] CMD_SUSP_FALL = 8'h05;
  localparam logic [7:0] CMD_PIN_LEVEL = 8'h06;
  localparam logic [7:0] CMD_ADDR_RESAMPLE = 8'h07;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h08;
  localparam logic [7:0] CMD_MAKER_IDENT = 8'hfe;

  // ==========================================================
  // reset values and fixed codes
  localparam logic [7:0] OUT_RESET_LOW = 8'h00;
  localparam logic [7:0] OUT_RESET_HIZ = 8'hff;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h19;
  // arbitrary identification value, not any real maker
  localparam logic [7:0] MAKER_IDENT_DEFAULT = 8'h5a;
  // default base address, selected by strap pins in low bits
  localparam logic [6:0] ADDR_BASE = 7'h20;

  // ==========================================================
  // carrier structs
  typedef struct packed {
    logic [7:0] output_state;
    logic [7:0] rise_mask;
    logic [7:0] fall_mask;
  } reg_set_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;

endpackage

// *** design/smbus_io_expander_alert.sv ***
/*
  Eight-line open-drain I/O expander with SMBus slave, edge interrupts,
  alert-response answer and normal/suspend register sets.
  Assumes SMBus clock and data, I/O pins, address straps, suspend select
  and thermal fault all come from outside the clock domain.
*/
// Operation
// RULE_01: pin change or thermal fault raises alert
// RULE_02: per-pin rise and fall masks gate edges
// RULE_03: all edge interrupts masked after reset
// RULE_04: thermal fault interrupt is never masked
// RULE_05: clear only by soft reset or alert response
// RULE_06: setting mask keeps pending interrupt
// RULE_07: alert-response read returns own address
// RULE_08: lowest address wins arbitration, loser quits
// RULE_09: arbitration loser keeps alert asserted
// RULE_10: clearing interrupt leaves registers unchanged
// RULE_11: codes 00h-05h select six read/write registers
// RULE_12: code 06h reads live pin levels
// RULE_13: code 07h resamples address pins
// RULE_14: code 08h resets registers, resamples address
// RULE_15: code FEh reads fixed maker byte
// RULE_16: output bit 0 pulls low, 1 releases
// RULE_17: output reset by variant, masks reset ones
// RULE_18: rise mask bit 0 enables, 1 masks
// RULE_19: pin levels sampled during the read
// RULE_20: reset states applied at power and soft reset
// RULE_21: suspend low selects suspend set
// RULE_22: data with 07h/08h goes to normal output; data sent with 08h is lost, the soft reset wins over the write
// RULE_23: data bytes travel most significant bit first
// RULE_24: alert held and re-raised while thermal fault
// RULE_25: edges from synchronized samples versus previous
// RULE_26: alert is open drain, active low
// RULE_27: unassigned codes ignore writes, read zero
`timescale 1ns/10ps
`default_nettype none

module smbus_io_expander_alert #(
  parameter bit OUT_HIZ_AT_RESET = 1'b0,
  parameter logic [7:0] MAKER_IDENT = ioexp_pkg::MAKER_IDENT_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_n_o,
  input wire logic [7:0] io_pin_i,
  output logic [7:0] io_pin_oe_n_o,
  input wire logic [1:0] addr_strap_i,
  input wire logic suspend_select_n_i,
  input wire logic thermal_fault_i,
  output logic alert_oe_n_o
);

  // ==========================================================
  // reset release
  logic [1:0] rst_sync;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // ==========================================================
  // input synchronisers
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic scl_s;
  logic sda_s;
  logic [7:0] pin_s;
  logic [1:0] strap_s;
  logic susp_n_s;
  logic fault_s;

  // two flip-flops on every outside input
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // idle levels: bus and pins high, fault clear
      sync_a <= 14'h3ffe;
      sync_b <= 14'h3ffe;
    end
    else
    begin
      sync_a <= {scl_i, sda_i, io_pin_i, addr_strap_i, suspend_select_n_i,
                 thermal_fault_i};
      sync_b <= sync_a;
    end
  end
  assign scl_s = sync_b[13];
  assign sda_s = sync_b[12];
  assign pin_s = sync_b[11:4];
  assign strap_s = sync_b[3:2];
  assign susp_n_s = sync_b[1];
  assign fault_s = sync_b[0];

  // ==========================================================
  // bus edge and condition detection
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // previous bus samples
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // slave state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_ACK,
    ST_RACK
  } bus_state_t;

  bus_state_t state;
  bus_state_t after_ack;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [3:0] bit_cnt;
  logic [7:0] command;
  logic [6:0] own_addr;
  logic ack_now;
  logic alert_read;
  logic lost_arb;
  logic got_cmd;
  logic wr_strobe;
  logic [7:0] wr_code;
  logic [7:0] wr_data;
  logic resample_req;
  logic soft_reset_req;
  logic alert_clear;
  logic load_read;
  logic pending_any;
  ioexp_pkg::reg_set_t normal_set;
  ioexp_pkg::reg_set_t suspend_set;

  // register read decode, unassigned codes read zero
  function automatic logic [7:0] read_mux(input logic [7:0] code,
                                          input logic [7:0] pins);
    begin
      unique case (code)
        ioexp_pkg::CMD_NORMAL_OUT: read_mux = normal_set.output_state;
        ioexp_pkg::CMD_NORMAL_RISE: read_mux = normal_set.rise_mask;
        ioexp_pkg::CMD_NORMAL_FALL: read_mux = normal_set.fall_mask;
        ioexp_pkg::CMD_SUSP_OUT: read_mux = suspend_set.output_state;
        ioexp_pkg::CMD_SUSP_RISE: read_mux = suspend_set.rise_mask;
        ioexp_pkg::CMD_SUSP_FALL: read_mux = suspend_set.fall_mask;
        ioexp_pkg::CMD_PIN_LEVEL: read_mux = pins; // see RULE_12
        ioexp_pkg::CMD_MAKER_IDENT: read_mux = MAKER_IDENT; // see RULE_15
        default: read_mux = ioexp_pkg::READ_ZERO; // see RULE_27
      endcase
    end
  endfunction

  // bus sequencing: address, command, data, acknowledge
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt <= 4'h0;
      command <= 8'h00;
      ack_now <= 1'b0;
      alert_read <= 1'b0;
      lost_arb <= 1'b0;
      got_cmd <= 1'b0;
      wr_strobe <= 1'b0;
      wr_code <= 8'h00;
      wr_data <= 8'h00;
      resample_req <= 1'b0;
      soft_reset_req <= 1'b0;
      alert_clear <= 1'b0;
      load_read <= 1'b0;
    end
    else
    begin
      wr_strobe <= 1'b0;
      resample_req <= 1'b0;
      soft_reset_req <= 1'b0;
      alert_clear <= 1'b0;
      load_read <= 1'b0;
      if (start_cond)
      begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        ack_now <= 1'b0;
        lost_arb <= 1'b0;
        alert_read <= 1'b0;
      end
      else if (stop_cond)
      begin
        // send-byte commands act at stop with no data byte; the
        // stop's own clock rise has already counted one bit
        if (got_cmd && state == ST_WDATA && bit_cnt <= 4'h1)
        begin
          resample_req <= (command == ioexp_pkg::CMD_ADDR_RESAMPLE) ||
                          (command == ioexp_pkg::CMD_SOFT_RESET);
          soft_reset_req <= (command == ioexp_pkg::CMD_SOFT_RESET);
        end
        state <= ST_IDLE;
        got_cmd <= 1'b0;
        ack_now <= 1'b0;
      end
      else if (scl_rise && (state == ST_ADDR || state == ST_CMD ||
                            state == ST_WDATA))
      begin
        // msb first on every byte, see RULE_23
        shift_in <= {shift_in[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_rise && state == ST_RDATA)
      begin
        // lose arbitration when we release but the line is low
        if (shift_out[7] && !sda_s && alert_read)
          lost_arb <= 1'b1; // see RULE_08
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_rise && state == ST_RACK)
      begin
        after_ack <= sda_s ? ST_IDLE : ST_RDATA;
        // a completed alert answer clears the pending flags
        if (alert_read && !lost_arb)
          alert_clear <= 1'b1; // see RULE_05
      end
      else if (scl_fall)
      begin
        unique case (state)
          ST_ADDR:
            if (bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (shift_in[7:1] == own_addr)
              begin
                ack_now <= 1'b1;
                state <= ST_ACK;
                after_ack <= shift_in[0] ? ST_RDATA : ST_CMD;
                load_read <= shift_in[0];
              end
              else if (shift_in == {ioexp_pkg::ALERT_RESP_ADDR, 1'b1} &&
                       pending_any)
              begin
                // see RULE_07
                ack_now <= 1'b1;
                alert_read <= 1'b1;
                state <= ST_ACK;
                after_ack <= ST_RDATA;
                shift_out <= {own_addr, 1'b0};
              end
              else
                state <= ST_IDLE;
            end
          ST_CMD:
            if (bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              command <= shift_in;
              got_cmd <= 1'b1;
              ack_now <= 1'b1;
              state <= ST_ACK;
              after_ack <= ST_WDATA;
            end
          ST_WDATA:
            if (bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              wr_strobe <= 1'b1;
              wr_code <= command;
              wr_data <= shift_in;
              // data sent with 07h/08h still performs the action
              resample_req <= (command == ioexp_pkg::CMD_ADDR_RESAMPLE) ||
                              (command == ioexp_pkg::CMD_SOFT_RESET);
              soft_reset_req <= (command == ioexp_pkg::CMD_SOFT_RESET);
              got_cmd <= 1'b0;
              ack_now <= 1'b1;
              state <= ST_ACK;
              after_ack <= ST_WDATA;
            end
          ST_ACK:
          begin
            ack_now <= 1'b0;
            state <= after_ack;
          end
          ST_RDATA:
            if (bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              state <= lost_arb ? ST_IDLE : ST_RACK;
            end
            else
              shift_out <= {shift_out[6:0], 1'b0};
          ST_RACK:
          begin
            state <= after_ack;
            load_read <= (after_ack == ST_RDATA) && !alert_read;
          end
          default: state <= ST_IDLE;
        endcase
      end
      // pin levels are captured at the moment the byte is loaded
      if (load_read)
        shift_out <= read_mux(command, pin_s); // see RULE_19
    end
  end

  // data line pull: acknowledge, or a zero data bit while reading
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sda_oe_n_o <= 1'b1;
    else
      sda_oe_n_o <= ~((state == ST_ACK && ack_now) ||
                      (state == ST_RDATA && !lost_arb &&
                       !shift_out[7])); // see RULE_08
  end

  // ==========================================================
  // slave address from straps
  logic rst_sync_first;
  logic [2:0] rst_seen;

  // one pulse on the third edge after release, once the straps have
  // crossed both synchroniser stages
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rst_seen <= 3'b000;
    else
      rst_seen <= {rst_seen[1:0], 1'b1};
  end
  assign rst_sync_first = rst_seen[1] & ~rst_seen[2];

  // resample straps after reset release and on command
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      own_addr <= ioexp_pkg::ADDR_BASE;
    else if (resample_req || rst_sync_first)
      own_addr <= ioexp_pkg::ADDR_BASE | {5'b00000, strap_s}; // see RULE_13
  end

  // ==========================================================
  // register file
  localparam ioexp_pkg::reg_set_t SET_RESET = '{
    output_state: OUT_HIZ_AT_RESET ? ioexp_pkg::OUT_RESET_HIZ :
                                     ioexp_pkg::OUT_RESET_LOW,
    rise_mask: ioexp_pkg::MASK_RESET,
    fall_mask: ioexp_pkg::MASK_RESET}; // see RULE_17, RULE_03

  // register writes; soft reset restores reset states
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      normal_set <= SET_RESET;
      suspend_set <= SET_RESET;
    end
    else if (rst_sync_first || soft_reset_req)
    begin
      normal_set <= SET_RESET; // see RULE_20, RULE_14
      suspend_set <= SET_RESET;
    end
    else if (wr_strobe)
    begin
      unique case (wr_code)
        ioexp_pkg::CMD_NORMAL_OUT, ioexp_pkg::CMD_ADDR_RESAMPLE,
        ioexp_pkg::CMD_SOFT_RESET, ioexp_pkg::CMD_MAKER_IDENT:
          normal_set.output_state <= wr_data; // see RULE_22
        ioexp_pkg::CMD_NORMAL_RISE: normal_set.rise_mask <= wr_data;
        ioexp_pkg::CMD_NORMAL_FALL: normal_set.fall_mask <= wr_data;
        ioexp_pkg::CMD_SUSP_OUT: suspend_set.output_state <= wr_data;
        ioexp_pkg::CMD_SUSP_RISE: suspend_set.rise_mask <= wr_data;
        ioexp_pkg::CMD_SUSP_FALL: suspend_set.fall_mask <= wr_data;
        default: ; // see RULE_11, RULE_27
      endcase
    end
  end

  // ==========================================================
  // pin drive and edge interrupts
  logic [7:0] out_sel;
  logic [7:0] rise_sel;
  logic [7:0] fall_sel;
  logic [7:0] pin_d;
  logic [7:0] rise_pend;
  logic [7:0] fall_pend;
  logic fault_pend;

  // suspend low picks the suspend set, see RULE_21
  assign out_sel = susp_n_s ? normal_set.output_state :
                              suspend_set.output_state;
  assign rise_sel = susp_n_s ? normal_set.rise_mask : suspend_set.rise_mask;
  assign fall_sel = susp_n_s ? normal_set.fall_mask : suspend_set.fall_mask;

  // pin drivers; zero bit enables the pull-down, see RULE_16
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      io_pin_oe_n_o <= 8'hff;
    else
      io_pin_oe_n_o <= out_sel;
  end

  // edge flags; setting wins over clearing, masks never clear
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_d <= 8'hff;
      rise_pend <= 8'h00;
      fall_pend <= 8'h00;
      fault_pend <= 1'b0;
    end
    else
    begin
      pin_d <= pin_s; // see RULE_25
      rise_pend <= (rise_pend & {8{~(alert_clear | soft_reset_req)}}) |
                   (pin_s & ~pin_d & ~rise_sel); // see RULE_02, RULE_18
      fall_pend <= (fall_pend & {8{~(alert_clear | soft_reset_req)}}) |
                   (~pin_s & pin_d & ~fall_sel); // see RULE_06, RULE_10
      fault_pend <= (fault_pend & ~(alert_clear | soft_reset_req)) |
                    fault_s; // see RULE_04, RULE_24
    end
  end
  assign pending_any = (|rise_pend) | (|fall_pend) | fault_pend;

  // alert line, pulled low while anything is pending
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      alert_oe_n_o <= 1'b1;
    else
      alert_oe_n_o <= ~pending_any; // see RULE_01, RULE_26, RULE_09
  end

endmodule

`default_nettype wire

// *** bench/smbus_io_expander_alert_asserts.sv ***
/*
  Port-level checker for the I/O expander top module.
  Assumes it is bound to the top module with the port names unchanged.
*/
`timescale 1ns/10ps
`default_nettype none
module ioexp_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n_o,
  input wire logic [7:0] io_pin_i,
  input wire logic [7:0] io_pin_oe_n_o,
  input wire logic [1:0] addr_strap_i,
  input wire logic suspend_select_n_i,
  input wire logic thermal_fault_i,
  input wire logic alert_oe_n_o
);
  logic [7:0] bus_age;
  logic [7:0] evt_age;
  logic [7:0] sus_age;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // activity ages
  // cycles since bus wires moved
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i || $changed(scl_i) || $changed(sda_i))
      bus_age <= 8'h00;
    else if (bus_age != 8'hff)
      bus_age <= bus_age + 8'h01;

  // cycles since a pin moved or the thermal fault was seen
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i || thermal_fault_i || $changed(io_pin_i))
      evt_age <= 8'h00;
    else if (evt_age != 8'hff)
      evt_age <= evt_age + 8'h01;

  // cycles since the suspend select moved
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i || $changed(suspend_select_n_i))
      sus_age <= 8'h00;
    else if (sus_age != 8'hff)
      sus_age <= sus_age + 8'h01;

  // ==========================================================
  // assertions
  a_reset_release: assert property (
    $rose(reset_n_i) |-> io_pin_oe_n_o == 8'hff && sda_oe_n_o
      && alert_oe_n_o)
    else $error("outputs not idle right after reset");
  a_thermal_alert: assert property (
    thermal_fault_i [*8] |-> ##[0:4] !alert_oe_n_o)
    else $error("thermal fault did not assert alert");
  a_alert_cause: assert property (
    $fell(alert_oe_n_o) |-> evt_age < 8'h0c)
    else $error("alert asserted with no pin or thermal event");
  a_alert_clear: assert property (
    $rose(alert_oe_n_o) |-> bus_age < 8'h30)
    else $error("alert released without bus traffic");
  a_out_quiet: assert property (
    $changed(io_pin_oe_n_o) |-> bus_age < 8'h30 || sus_age < 8'h08)
    else $error("pin drivers changed without cause");
  a_sda_drive_low: assert property (
    $fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 3))
    else $error("data line pulled while clock high");
  a_sda_hold: assert property (
    !$past(sda_oe_n_o) && $past(scl_i) && scl_i |-> !sda_oe_n_o)
    else $error("data line released while clock high");
  a_sda_idle: assert property (
    bus_age == 8'hff |-> sda_oe_n_o)
    else $error("data line pulled on an idle bus");
endmodule

bind smbus_io_expander_alert ioexp_chk chk (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_oe_n_o(sda_oe_n_o), .io_pin_i(io_pin_i),
  .io_pin_oe_n_o(io_pin_oe_n_o), .addr_strap_i(addr_strap_i),
  .suspend_select_n_i(suspend_select_n_i),
  .thermal_fault_i(thermal_fault_i), .alert_oe_n_o(alert_oe_n_o)
);
`default_nettype wire

// *** bench/smbus_host_model.sv ***
/*
  Behavioural bus host: write, read, send and alert-response cycles.
  Assumes an open-drain data wire with pull-up resolved by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
  output var logic scl_o,
  output var logic sda_oe_n_o,
  input wire logic sda_i
);
  // clock stands high and data is released between frames
  initial
  begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // ==========================================================
  // bit, byte and framing
  // data set mid low phase, sampled mid high phase
  task automatic xbit(input logic b, output logic r);
    #20 sda_oe_n_o = b;
    #20 scl_o = 1'b1;
    #20 r = sda_i;
    #20 scl_o = 1'b0;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic a,
      output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r[i]);
    xbit(a, k);
  endtask

  // start or repeated start
  task automatic start();
    #20 sda_oe_n_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_oe_n_o = 1'b0;
    #20 scl_o = 1'b0;
  endtask

  task automatic stop();
    #20 sda_oe_n_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_oe_n_o = 1'b1;
    #20;
  endtask

  // kind 0 write, 1 read, 2 send, 3 alert response
  task automatic txn(input logic [1:0] kind, input logic [6:0] a,
      input logic [7:0] c, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    logic [7:0] r;
    logic k;
    q = 8'h00;
    start();
    if (kind == 2'h3)
    begin
      xbyte({ioexp_pkg::ALERT_RESP_ADDR, 1'b1}, 1'b1, r, k);
      ok = !k;
    end
    else
    begin
      xbyte({a, 1'b0}, 1'b1, r, k);
      ok = !k;
      xbyte(c, 1'b1, r, k);
      ok = ok && !k;
      if (kind == 2'h0)
        xbyte(d, 1'b1, r, k);
      if (kind == 2'h1)
      begin
        start();
        xbyte({a, 1'b1}, 1'b1, r, k);
      end
      ok = ok && !k;
    end
    if (kind[0])
      xbyte(8'hff, 1'b1, q, k);
    stop();
  endtask
endmodule
`default_nettype wire

// *** bench/tb_smbus_io_expander_alert.sv ***
/*
  Self-checking bench for the I/O expander with a behavioural bus host.
  Assumes the package and the design are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_smbus_io_expander_alert;
  logic sys_clk;
  logic rst_n;
  logic scl;
  logic h_sda_n;
  logic d_sda_n;
  logic [7:0] ext;
  logic [7:0] oe_n;
  logic [1:0] strap;
  logic sus_n;
  logic therm;
  logic alert_n;
  logic [6:0] dev;
  logic [7:0] q;
  logic ok;
  logic [7:0] vals [6];
  logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'hfe, 8'h0a};
  integer seed;
  int err_count;
  int cmp_count;
  wire logic sda = h_sda_n & d_sda_n;
  wire logic [7:0] pins = oe_n & ext;

  // ==========================================================
  // design, host and clock
  smbus_io_expander_alert #(.OUT_HIZ_AT_RESET(1'b0)) uut (
    .sys_clk_i(sys_clk), .reset_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_oe_n_o(d_sda_n), .io_pin_i(pins), .io_pin_oe_n_o(oe_n),
    .addr_strap_i(strap), .suspend_select_n_i(sus_n),
    .thermal_fault_i(therm), .alert_oe_n_o(alert_n));
  smbus_host_model host (.scl_o(scl), .sda_oe_n_o(h_sda_n), .sda_i(sda));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // expectations and helpers
  function automatic logic [6:0] exp_addr(input logic [1:0] s);
    return ioexp_pkg::ADDR_BASE | {5'h00, s};
  endfunction

  function automatic logic [7:0] exp_reset(input logic [7:0] c);
    case (c)
      8'h00, 8'h03: return ioexp_pkg::OUT_RESET_LOW;
      8'h01, 8'h02, 8'h04, 8'h05: return ioexp_pkg::MASK_RESET;
      8'h06: return ioexp_pkg::OUT_RESET_LOW; // reset outputs pull pins low
      8'hfe: return ioexp_pkg::MAKER_IDENT_DEFAULT;
      default: return ioexp_pkg::READ_ZERO;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    host.txn(2'h0, dev, c, v, q, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] c);
    host.txn(2'h1, dev, c, 8'h00, q, ok);
  endtask

  task automatic cmd(input logic [7:0] c);
    host.txn(2'h2, dev, c, 8'h00, q, ok);
  endtask

  task automatic query();
    host.txn(2'h3, dev, 8'h00, 8'h00, q, ok);
    chk(q, {dev, 1'b0});
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic drive_ext(input logic [7:0] v);
    @(negedge sys_clk);
    ext = v;
  endtask

  task automatic alert_is(input logic v);
    repeat (12) @(negedge sys_clk);
    chk({7'h00, alert_n}, {7'h00, v});
  endtask

  task automatic reset_table();
    foreach (codes[k])
    begin
      rd(codes[k]);
      chk(q, exp_reset(codes[k]));
    end
  endtask

  // watchdog
  initial
  begin
    #300000;
    err_count++;
    summarize();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 80;
    err_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    ext = 8'hff;
    strap = 2'h1;
    sus_n = 1'b1;
    therm = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (12) @(negedge sys_clk);
    dev = exp_addr(strap);
    chk(oe_n, ioexp_pkg::OUT_RESET_LOW);
    reset_table();
    // random traffic to the six read/write registers
    for (int i = 0; i < 12; i++)
    begin
      vals[i % 6] = 8'($random(seed));
      wr(8'(i % 6), vals[i % 6]);
      rd(8'(i % 6));
      chk(q, vals[i % 6]);
    end
    chk(oe_n, vals[0]);
    @(negedge sys_clk);
    sus_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(oe_n, vals[3]);
    sus_n = 1'b1;
    wr(ioexp_pkg::CMD_ADDR_RESAMPLE, 8'ha5);
    rd(8'h00);
    chk(q, 8'ha5);
    cmd(ioexp_pkg::CMD_SOFT_RESET);
    host.txn(2'h0, dev, 8'h0a, 8'h3c, q, ok);
    reset_table();
    // live pin levels, sampled per read
    wr(8'h00, 8'hff);
    repeat (2)
    begin
      drive_ext(8'($random(seed)));
      rd(ioexp_pkg::CMD_PIN_LEVEL);
      chk(q, ext);
    end
    // edge interrupts, masking and clearing
    drive_ext(8'h00);
    alert_is(1'b1);
    wr(8'h01, 8'hf7);
    drive_ext(8'h08);
    alert_is(1'b0);
    wr(8'h01, 8'hff);
    alert_is(1'b0);
    query();
    alert_is(1'b1);
    rd(8'h01);
    chk(q, 8'hff);
    wr(8'h02, 8'hf7);
    drive_ext(8'h00);
    alert_is(1'b0);
    cmd(ioexp_pkg::CMD_SOFT_RESET);
    alert_is(1'b1);
    // thermal fault ignores masks and survives a clear
    @(negedge sys_clk);
    therm = 1'b1;
    alert_is(1'b0);
    query();
    alert_is(1'b0);
    @(negedge sys_clk);
    therm = 1'b0;
    query();
    alert_is(1'b1);
    // address resample moves the device
    @(negedge sys_clk);
    strap = 2'h2;
    cmd(ioexp_pkg::CMD_ADDR_RESAMPLE);
    rd(ioexp_pkg::CMD_MAKER_IDENT);
    chk({7'h00, ok}, 8'h00);
    dev = exp_addr(strap);
    rd(ioexp_pkg::CMD_MAKER_IDENT);
    chk(q, ioexp_pkg::MAKER_IDENT_DEFAULT);
    summarize();
  end
endmodule
`default_nettype wire
